// ==== acs_pkg.sv ====
// constants, register map and state encoding of the conversion sequencer
// assumes a single 125 MHz system clock and an APB register bus
package acs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_RES_HI = 8'h08;
   localparam logic [7:0] ADDR_RES_LO = 8'h0C;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL0_ENABLE_BIT = 0;
   localparam int CTRL0_GO_BIT = 1;
   localparam int CTRL0_CHAN_LSB = 2;
   localparam int CTRL0_CLKSEL_LSB = 6;
   localparam int CTRL1_REF_POS_BIT = 4;
   localparam int CTRL1_REF_NEG_BIT = 5;
   localparam int CTRL1_JUSTIFY_BIT = 7;
   localparam int FLAGS_DONE_BIT = 0;
   localparam int FLAGS_IRQ_EN_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and the first trial code
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [2:0] CLKSEL_RESET = 3'h0;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [9:0] SAR_TRIAL_MSB = 10'h200;

   ////////////////////////////////////////////////////////////////////////////
   // clock select encodings and timing counts
   localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
   localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
   localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
   localparam logic [1:0] CLKSEL_FRC_LOW = 2'h3;
   localparam logic [5:0] DIV2_CLKS = 6'h02;
   localparam logic [5:0] DIV8_CLKS = 6'h08;
   localparam logic [5:0] DIV32_CLKS = 6'h20;
   localparam logic [3:0] CONV_PERIODS = 4'hB;
   localparam logic [3:0] ABORT_PERIODS = 4'h2;
   localparam logic [2:0] INSTR_CYCLE_CLKS = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_CONV = 4'b0100,
      ST_ABORT = 4'b1000
   } acs_state_t;

endpackage

// ==== acs_tad_gen.sv ====
// conversion bit period tick generator
// assumes frc_pin is asynchronous to clk; clk is the system clock
`timescale 1ns/1ps
module acs_tad_gen
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] clk_sel,
   input wire logic run,
   input wire logic frc_pin,
   output logic tad_tick
);
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic [5:0] limit;
   logic frc_sel;
   logic div_tick;
   logic frc_tick;
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic frc_level_q;

   ////////////////////////////////////////////////////////////////////////////
   // divided system clock
   assign frc_sel = (clk_sel[1:0] == CLKSEL_FRC_LOW);
   assign limit = (clk_sel[1:0] == CLKSEL_DIV8[1:0]) ? DIV8_CLKS :
                  (clk_sel[1:0] == CLKSEL_DIV32[1:0]) ? DIV32_CLKS : DIV2_CLKS;  // R2
   assign div_tick = run & ~frc_sel & (cnt_q == limit - 6'h01);  // R3
   assign cnt_d = (~run | div_tick) ? 6'h00 : cnt_q + 6'h01;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 6'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal oscillator brought into the system clock domain
   assign frc_tick = run & frc_sel & (sync2_q == sync3_q) & sync3_q & ~frc_level_q;  // R23

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         frc_level_q <= 1'b0;
      end else begin
         sync1_q <= frc_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            frc_level_q <= sync3_q;
         end
      end
   end

   assign tad_tick = div_tick | frc_tick;
endmodule // acs_tad_gen

// ==== acs_res_fmt.sv ====
// result justification into the high and low result bytes
// assumes a stable registered 10-bit result at its input
`timescale 1ns/1ps
module acs_res_fmt
   import acs_pkg::*;
(
   input wire logic [9:0] result,
   input wire logic justify_right,
   output logic [7:0] res_hi,
   output logic [7:0] res_lo
);
   assign res_hi = justify_right ? {6'h00, result[9:8]} : result[9:2];  // R9
   assign res_lo = justify_right ? result[7:0] : {result[1:0], 6'h00};  // R9
endmodule // acs_res_fmt

// ==== acs_top.sv ====
// conversion sequencer of a 10-bit successive approximation converter
// assumes COMP_IN and SLEEP_MODE and EVENT_TRIG are synchronous to REF_CLK
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// R1 - eleven bit periods per ten-bit conversion
// R2 - bit period from div2, div8, div32, oscillator
// R3 - divided clocks follow the system clock
// R4 - independent positive and negative reference selects
// R5 - done flag set on every completed conversion
// R6 - software clears the done flag itself
// R7 - completion wakes from sleep when enabled
// R8 - one bit picks left or right justify
// R9 - justified byte layout of the result
// R10 - enable required; writing go starts conversion
// R11 - enable first, start in later write
// R12 - go reads one only while converting; a start in the cycle of a write clearing enable leaves go at one in idle
// R13 - completion clears go, flags, loads result
// R14 - software abort keeps the previous result
// R15 - after abort wait two periods, reacquire
// R16 - reset clears registers and stops conversion
// R17 - oscillator source delays start one instruction
// R18 - sleeping oscillator without interrupt shuts down
// R19 - sleep with other source aborts, shuts down
// R20 - compare trigger starts conversion, clears timer
// R21 - software waits acquisition, then polls or interrupt
// R22 - four-bit channel code, codes 14 and 15
// R23 - oscillator ticks synchronised to system clock
// R24 - aborts never set the done flag
module acs_top
   import acs_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic FRC_CLK,
   input wire logic SLEEP_MODE,
   input wire logic EVENT_TRIG,
   input wire logic COMP_IN,
   output logic [9:0] SAR_CODE,
   output logic SAMPLE_ACQUIRE,
   output logic ANALOG_ON,
   output logic [3:0] CHANNEL_SEL,
   output logic REF_POS_EXT,
   output logic REF_NEG_EXT,
   output logic CONV_DONE_FLAG,
   output logic WAKE_REQ,
   output logic TIMER_CLEAR
);
   import acs_pkg::*;

   acs_state_t state_q;
   acs_state_t state_d;
   logic enable_q;
   logic go_q;
   logic go_d;
   logic [3:0] chan_q;
   logic [2:0] clksel_q;
   logic justify_q;
   logic ref_pos_q;
   logic ref_neg_q;
   logic flag_q;
   logic flag_d;
   logic irq_en_q;
   logic shutdown_q;
   logic shutdown_d;
   logic [9:0] result_q;
   logic [9:0] sar_q;
   logic [9:0] sar_d;
   logic [3:0] period_q;
   logic [3:0] period_d;
   logic [2:0] delay_q;
   logic wake_q;
   logic timer_clr_q;
   logic [31:0] prdata_q;
   logic tad_tick;
   logic [7:0] res_hi;
   logic [7:0] res_lo;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire wr_access = PSEL & PENABLE & PWRITE;
   wire hit_ctrl0 = (PADDR == ADDR_CTRL0);
   wire hit_ctrl1 = (PADDR == ADDR_CTRL1);
   wire hit_res_hi = (PADDR == ADDR_RES_HI);
   wire hit_res_lo = (PADDR == ADDR_RES_LO);
   wire hit_flags = (PADDR == ADDR_FLAGS);
   wire addr_hit = hit_ctrl0 | hit_ctrl1 | hit_res_hi | hit_res_lo | hit_flags;
   wire wr_ctrl0 = wr_access & hit_ctrl0;
   wire wr_ctrl1 = wr_access & hit_ctrl1;
   wire wr_flags = wr_access & hit_flags;
   wire setup = PSEL & ~PENABLE;

   ////////////////////////////////////////////////////////////////////////////
   // sequencing terms
   wire frc_sel = (clksel_q[1:0] == CLKSEL_FRC_LOW);
   wire st_idle = (state_q == ST_IDLE);
   wire st_delay = (state_q == ST_DELAY);
   wire st_conv = (state_q == ST_CONV);
   wire st_abort = (state_q == ST_ABORT);
   wire busy = st_delay | st_conv;
   wire sw_start = wr_ctrl0 & PWDATA[CTRL0_GO_BIT];
   wire start = st_idle & enable_q & ~shutdown_q & (sw_start | EVENT_TRIG);  // R10 R20
   wire trig_start = start & EVENT_TRIG;  // R20
   wire sw_abort = busy & wr_ctrl0 & ~PWDATA[CTRL0_GO_BIT] & PWDATA[CTRL0_ENABLE_BIT];  // R14
   wire disable_stop = wr_ctrl0 & ~PWDATA[CTRL0_ENABLE_BIT];
   wire sleep_abort = busy & SLEEP_MODE & ~frc_sel & ~disable_stop;  // R19
   wire done = st_conv & tad_tick & (period_q == CONV_PERIODS - 4'h1) & ~sw_abort
               & ~disable_stop & ~sleep_abort;  // R1
   wire [3:0] dec_idx = 4'h9 - (period_q - 4'h1);
   wire decide = st_conv & tad_tick & (period_q != 4'h0);
   wire tad_run = (st_conv | st_abort) & ~sw_abort;  // R15

   ////////////////////////////////////////////////////////////////////////////
   // bit period source and result layout
   acs_tad_gen u_tad (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .clk_sel(clksel_q),
      .run(tad_run),
      .frc_pin(FRC_CLK),
      .tad_tick(tad_tick)
   );

   acs_res_fmt u_fmt (
      .result(result_q),
      .justify_right(justify_q),
      .res_hi(res_hi),
      .res_lo(res_lo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_d = state_q;
      period_d = period_q;
      case (state_q)
         ST_IDLE: begin
            period_d = 4'h0;
            if (start) begin
               state_d = frc_sel ? ST_DELAY : ST_CONV;  // R17
            end
         end
         ST_DELAY: begin
            if (delay_q == INSTR_CYCLE_CLKS - 3'h1) begin
               state_d = ST_CONV;  // R17
            end
         end
         ST_CONV: begin
            if (tad_tick) begin
               period_d = period_q + 4'h1;
            end
            if (done) begin
               state_d = ST_IDLE;
            end
         end
         ST_ABORT: begin
            if (tad_tick) begin
               period_d = period_q + 4'h1;
               if (period_q == ABORT_PERIODS - 4'h1) begin
                  state_d = ST_IDLE;  // R15
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (sw_abort) begin
         state_d = ST_ABORT;  // R15
         period_d = 4'h0;
      end
      if (disable_stop | sleep_abort) begin
         state_d = ST_IDLE;  // R19
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // successive approximation register, one trial bit per period
   genvar gi;
   generate
      for (gi = 0; gi < 10; gi++) begin : g_sar
         assign sar_d[gi] = start ? SAR_TRIAL_MSB[gi] :
                            (decide & (dec_idx == 4'(gi))) ? COMP_IN :
                            (decide & (dec_idx == 4'(gi + 1))) ? 1'b1 : sar_q[gi];  // R1
      end
   endgenerate

   assign go_d = start ? 1'b1 :
                 (done | sw_abort | sleep_abort | disable_stop) ? 1'b0 : go_q;  // R13
   assign flag_d = done ? 1'b1 :
                   wr_flags ? PWDATA[FLAGS_DONE_BIT] : flag_q;  // R5 R6 R24
   assign shutdown_d = ~SLEEP_MODE ? 1'b0 :
                       (sleep_abort | (done & frc_sel & ~irq_en_q)) ? 1'b1 : shutdown_q;  // R18

   ////////////////////////////////////////////////////////////////////////////
   // sequencer flops
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;  // R16
         period_q <= 4'h0;
         delay_q <= 3'h0;
         sar_q <= RESULT_RESET;
         go_q <= 1'b0;
         flag_q <= 1'b0;
         shutdown_q <= 1'b0;
         wake_q <= 1'b0;
         timer_clr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         period_q <= period_d;
         delay_q <= st_delay ? delay_q + 3'h1 : 3'h0;
         sar_q <= sar_d;
         go_q <= go_d;  // R12
         flag_q <= flag_d;
         shutdown_q <= shutdown_d;
         wake_q <= done & irq_en_q & SLEEP_MODE;  // R7
         timer_clr_q <= trig_start;  // R20
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         enable_q <= 1'b0;  // R16
         chan_q <= CHAN_RESET;
         clksel_q <= CLKSEL_RESET;
         justify_q <= 1'b0;
         ref_pos_q <= 1'b0;
         ref_neg_q <= 1'b0;
         irq_en_q <= 1'b0;
         result_q <= RESULT_RESET;
      end else begin
         if (wr_ctrl0) begin
            enable_q <= PWDATA[CTRL0_ENABLE_BIT];  // R10
            chan_q <= PWDATA[CTRL0_CHAN_LSB +: 4];  // R22
            clksel_q <= PWDATA[CTRL0_CLKSEL_LSB +: 3];  // R2
         end
         if (wr_ctrl1) begin
            justify_q <= PWDATA[CTRL1_JUSTIFY_BIT];  // R8
            ref_pos_q <= PWDATA[CTRL1_REF_POS_BIT];  // R4
            ref_neg_q <= PWDATA[CTRL1_REF_NEG_BIT];  // R4
         end
         if (wr_flags) begin
            irq_en_q <= PWDATA[FLAGS_IRQ_EN_BIT];
         end
         if (done) begin
            result_q <= sar_d;  // R13 R14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data captured in the setup cycle
   wire [31:0] rd_mux =
      hit_ctrl0 ? {23'h0, clksel_q, chan_q, go_q, enable_q} :
      hit_ctrl1 ? {24'h0, justify_q, 1'b0, ref_neg_q, ref_pos_q, 4'h0} :
      hit_res_hi ? {24'h0, res_hi} :
      hit_res_lo ? {24'h0, res_lo} :
      hit_flags ? {30'h0, irq_en_q, flag_q} : 32'h0000_0000;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~addr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // analog side outputs
   assign SAR_CODE = sar_q;
   assign ANALOG_ON = enable_q & ~shutdown_q;  // R18 R19
   assign SAMPLE_ACQUIRE = ANALOG_ON & st_idle;  // R15
   assign CHANNEL_SEL = chan_q;  // R22
   assign REF_POS_EXT = ref_pos_q;
   assign REF_NEG_EXT = ref_neg_q;
   assign CONV_DONE_FLAG = flag_q;
   assign WAKE_REQ = wake_q;
   assign TIMER_CLEAR = timer_clr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   conv_length_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R1
      done |-> (period_q == 4'hA) && tad_tick)
      else $error("conversion ended at wrong period count");
   flag_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R5
      done |=> flag_q && CONV_DONE_FLAG)
      else $error("done flag not set after completion");
   done_update_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R13
      done |=> !go_q && (result_q == $past(sar_d)) && st_idle)
      else $error("completion did not clear go or load result");
   go_state_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R12
      go_q == (st_delay || st_conv))
      else $error("go bit disagrees with sequencer state");
   abort_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R14
      sw_abort |=> $stable(result_q) && st_abort && !go_q)
      else $error("abort changed the result");
   abort_wait_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R15
      (st_abort && tad_tick && period_q == 4'h1 && !wr_ctrl0) |=> st_idle)
      else $error("abort wait not two periods");
   frc_delay_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R17
      (start && frc_sel) |=> (st_delay && !wr_ctrl0) [*4] |=> st_conv)
      else $error("oscillator start delay wrong");
   no_abort_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R24
      (sw_abort || sleep_abort || disable_stop) && !flag_q && !wr_flags |=> !flag_q)
      else $error("abort set the done flag");
   sleep_abort_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R19
      sleep_abort |=> st_idle && !ANALOG_ON && enable_q)
      else $error("sleep did not abort and shut down");
   trig_timer_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R20
      trig_start |=> TIMER_CLEAR && go_q)
      else $error("trigger did not start and clear timer");
   wake_req_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R7
      done && irq_en_q && SLEEP_MODE |=> WAKE_REQ)
      else $error("completion in sleep did not request wake");
   frc_sleep_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R18
      done && frc_sel && !irq_en_q && SLEEP_MODE |=> !ANALOG_ON && enable_q)
      else $error("sleeping oscillator conversion did not shut down");
   enable_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R10
      disable_stop |=> st_idle && !go_q && !ANALOG_ON)
      else $error("clearing enable did not stop the converter");
   sar_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R1
      start |=> (SAR_CODE == SAR_TRIAL_MSB) && (period_q == 4'h0))
      else $error("conversion did not begin with the top trial bit");
   abort_restart_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R15
      sw_abort |=> st_abort && (period_q == 4'h0) && (!tad_tick || frc_sel))
      else $error("abort wait did not restart the bit period");
   timer_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)  // R20
      TIMER_CLEAR |-> $past(EVENT_TRIG) && go_q)
      else $error("timer clear without a trigger");
endmodule // acs_top

// ==== acs_analog_model.sv ====
// far-side model: channel levels, sample and hold, comparator
// assumes sar_code is the registered trial code and comp_in is sampled on clk
`timescale 1ns/1ps
module acs_analog_model (
   input wire logic clk,
   input wire logic [9:0] sar_code,
   input wire logic sample_acquire,
   input wire logic analog_on,
   input wire logic [3:0] channel_sel,
   output logic comp_in
);
   logic [9:0] held_q = 10'h000;
   logic junk_q = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   // each channel code carries its own level, held while not tracking
   always @(posedge clk) begin
      if (sample_acquire) begin
         held_q <= {channel_sel, 6'h2B};
      end
      junk_q <= ~junk_q;
   end
   // a powered-down comparator gives no stable answer
   assign comp_in = analog_on ? (held_q >= sar_code) : junk_q;
endmodule // acs_analog_model

// ==== acs_top_tb_top.sv ====
// self-checking bench of the conversion sequencer
// assumes the analog model on the far side and an APB master driven here
`timescale 1ns/1ps
module acs_top_tb_top;
   import acs_pkg::*;
   logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic FRC_CLK = 0, SLEEP_MODE = 0, EVENT_TRIG = 0, er, wk;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, rd;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, COMP_IN, SAMPLE_ACQUIRE, ANALOG_ON, REF_POS_EXT, REF_NEG_EXT;
   logic CONV_DONE_FLAG, WAKE_REQ, TIMER_CLEAR;
   logic [9:0] SAR_CODE;
   logic [3:0] CHANNEL_SEL;
   int error_cnt = 0, check_count = 0, n;
   acs_top i_acs_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .FRC_CLK(FRC_CLK), .SLEEP_MODE(SLEEP_MODE), .EVENT_TRIG(EVENT_TRIG),
      .COMP_IN(COMP_IN), .SAR_CODE(SAR_CODE), .SAMPLE_ACQUIRE(SAMPLE_ACQUIRE),
      .ANALOG_ON(ANALOG_ON), .CHANNEL_SEL(CHANNEL_SEL), .REF_POS_EXT(REF_POS_EXT),
      .REF_NEG_EXT(REF_NEG_EXT), .CONV_DONE_FLAG(CONV_DONE_FLAG), .WAKE_REQ(WAKE_REQ),
      .TIMER_CLEAR(TIMER_CLEAR));
   acs_analog_model i_acs_analog_model (.clk(REF_CLK), .sar_code(SAR_CODE),
      .sample_acquire(SAMPLE_ACQUIRE), .analog_on(ANALOG_ON), .channel_sel(CHANNEL_SEL),
      .comp_in(COMP_IN));
   always #4 REF_CLK = ~REF_CLK;
   always #50 FRC_CLK = ~FRC_CLK;
   ////////////////////////////////////////////////////////////////////////////
   task end_sim;
      if (error_cnt == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge REF_CLK);
      PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge REF_CLK);
         if (PREADY === 1'b1) break;
      end
      if (i == 16) begin
         chk(0, 1, "bus hang");
         end_sim;
      end
      rd = PRDATA; er = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
      @(posedge REF_CLK);
   endtask
   // counts edges after the start write until the done flag shows
   task wait_done(input int lim);
      #1; n = 1; wk = 0;
      while (CONV_DONE_FLAG !== 1'b1 && n < lim) begin
         @(posedge REF_CLK); #1; n++;
         if (WAKE_REQ === 1'b1) wk = 1;
      end
      if (n >= lim) begin
         chk(0, 1, "done timeout");
         end_sim;
      end
   endtask
   task start(input logic [2:0] cs, input logic [3:0] ch, input logic [31:0] fl);
      apb(1, ADDR_FLAGS, fl);
      apb(1, ADDR_CTRL0, (cs << 6) | (ch << 2) | 1);
      repeat (4) @(posedge REF_CLK);
      apb(1, ADDR_CTRL0, (cs << 6) | (ch << 2) | 3);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      apb(0, ADDR_CTRL0, 0); chk(rd, 0, "ctrl0 reset");
      apb(0, ADDR_CTRL1, 0); chk(rd, 0, "ctrl1 reset");
      apb(0, ADDR_FLAGS, 0); chk(rd, 0, "flags reset");
      chk(ANALOG_ON, 0, "off at reset");
      apb(0, 8'h14, 0); chk(er, 1, "unmapped read");
      apb(1, 8'h14, 32'hFFFFFFFF); chk(er, 1, "unmapped write");
   endtask
   task t_ref;
      apb(1, ADDR_CTRL1, 32'h10); #1;
      chk({REF_POS_EXT, REF_NEG_EXT}, 2'b10, "ref pos");
      apb(1, ADDR_CTRL1, 32'h20); #1;
      chk({REF_POS_EXT, REF_NEG_EXT}, 2'b01, "ref neg");
      apb(0, ADDR_CTRL1, 0); chk(rd, 32'h20, "ctrl1 readback");
   endtask
   task conv(input logic [2:0] cs, input logic [3:0] ch, input logic rj, input int n_exp);
      logic [9:0] r;
      r = {ch, 6'h2B};
      apb(1, ADDR_CTRL1, {24'h00, rj, 7'h00});
      start(cs, ch, 0);
      chk(CHANNEL_SEL, ch, "channel");
      if (n_exp == 0) begin
         apb(0, ADDR_CTRL0, 0); chk(rd[1], 1, "go while busy");
      end
      wait_done(2000);
      chk(SAR_CODE, r, "final trial code");
      if (n_exp > 0) chk(n, n_exp, "conversion length");
      apb(0, ADDR_CTRL0, 0); chk(rd[1], 0, "go after done");
      apb(0, ADDR_FLAGS, 0); chk(rd[0], 1, "flag on done");
      apb(0, ADDR_RES_HI, 0);
      if (rj) chk(rd[1:0], r[9:8], "right high");
      else chk(rd[7:0], r[9:2], "left high");
      apb(0, ADDR_RES_LO, 0);
      if (rj) chk(rd[7:0], r[7:0], "right low");
      else chk(rd[7:6], r[1:0], "left low");
      repeat (30) @(posedge REF_CLK);
      #1; chk(CONV_DONE_FLAG, 1, "flag sticky");
   endtask
   task t_abort;
      logic [31:0] h0, l0;
      apb(0, ADDR_RES_HI, 0); h0 = rd;
      apb(0, ADDR_RES_LO, 0); l0 = rd;
      start(3'h2, 4'h2, 0);
      repeat (40) @(posedge REF_CLK);
      apb(1, ADDR_CTRL0, (2 << 6) | (2 << 2) | 1);
      #1; n = 1;
      while (SAMPLE_ACQUIRE !== 1'b1 && n < 200) begin
         @(posedge REF_CLK); #1; n++;
      end
      chk(n, 64, "abort wait");
      apb(0, ADDR_RES_HI, 0); chk(rd, h0, "high kept");
      apb(0, ADDR_RES_LO, 0); chk(rd, l0, "low kept");
      apb(0, ADDR_FLAGS, 0); chk(rd[0], 0, "no flag on abort");
   endtask
   task t_samewrite;
      apb(1, ADDR_FLAGS, 0);
      apb(1, ADDR_CTRL0, 32'h0); apb(1, ADDR_CTRL0, 32'h2);
      apb(1, ADDR_CTRL0, 32'h3);
      apb(0, ADDR_CTRL0, 0); chk(rd[1], 0, "go ignored");
      repeat (40) @(posedge REF_CLK);
      #1; chk(CONV_DONE_FLAG, 0, "no conversion");
   endtask
   task t_sleep_abort;
      start(3'h1, 4'h4, 0);
      repeat (10) @(posedge REF_CLK);
      SLEEP_MODE <= 1'b1;
      repeat (4) @(posedge REF_CLK);
      #1; chk(ANALOG_ON, 0, "sleep shutdown");
      apb(0, ADDR_CTRL0, 0); chk(rd[0], 1, "enable kept");
      repeat (100) @(posedge REF_CLK);
      #1; chk(CONV_DONE_FLAG, 0, "no flag on sleep");
      @(posedge REF_CLK);
      SLEEP_MODE <= 1'b0;
      repeat (4) @(posedge REF_CLK);
      #1; chk(ANALOG_ON, 1, "power back");
   endtask
   task t_sleep_frc(input logic ie);
      start(3'h3, 4'h6, {30'h0, ie, 1'b0});
      SLEEP_MODE <= 1'b1;
      #1; chk(SAMPLE_ACQUIRE, 0, "acquire ended at start");
      wait_done(600);
      chk(wk, ie, "wake request");
      repeat (3) @(posedge REF_CLK);
      #1; chk(ANALOG_ON, ie, "off after sleep conversion");
      apb(0, ADDR_CTRL0, 0); chk(rd[0], 1, "enable kept");
      SLEEP_MODE <= 1'b0;
      repeat (4) @(posedge REF_CLK);
   endtask
   task t_trig;
      apb(1, ADDR_FLAGS, 0);
      apb(1, ADDR_CTRL0, (7 << 2) | 1);
      EVENT_TRIG <= 1'b1;
      @(posedge REF_CLK);
      EVENT_TRIG <= 1'b0;
      #1; chk(TIMER_CLEAR, 1, "timer clear");
      @(posedge REF_CLK);
      #1; chk(TIMER_CLEAR, 0, "timer clear pulse");
      wait_done(100);
      apb(0, ADDR_CTRL0, 0); chk(rd[1], 0, "trigger conversion done");
   endtask
   task t_midreset;
      start(3'h2, 4'h1, 0);
      repeat (20) @(posedge REF_CLK);
      RST_N <= 1'b0;
      @(posedge REF_CLK);
      RST_N <= 1'b1;
      #1; chk(ANALOG_ON, 0, "reset stops");
      @(posedge REF_CLK);
      apb(0, ADDR_CTRL0, 0); chk(rd, 0, "ctrl0 after reset");
      repeat (400) @(posedge REF_CLK);
      #1; chk(CONV_DONE_FLAG, 0, "no flag after reset");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge REF_CLK);
      RST_N <= 1'b1;
      @(posedge REF_CLK);
      t_reset;
      t_ref;
      conv(3'h0, 4'h5, 0, 22);
      conv(3'h1, 4'hE, 1, 88);
      conv(3'h2, 4'hF, 0, 352);
      conv(3'h3, 4'h9, 1, 0);
      conv(3'h7, 4'h3, 0, 0);
      t_abort;
      t_samewrite;
      t_sleep_abort;
      t_sleep_frc(1'b1);
      t_sleep_frc(1'b0);
      t_trig;
      t_midreset;
      end_sim;
   end
endmodule // acs_top_tb_top
